// File: design/lsaf_filter.v
// luma sharpness and adaptive edge filter with axi4-lite registers
`timescale 1ns/1ps
`include "lsaf_defines.vh"
module lsaf_filter
#(
   parameter DW    = 10,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire          clk_sys_i,
   input  wire          rstn_i,
   input  wire [DW-1:0] luma_in_data_i,
   input  wire          luma_in_valid_i,
   output wire          luma_in_ready_o,
   output reg  [DW-1:0] luma_out_data_o,
   output reg           luma_out_valid_o,
   input  wire          luma_out_ready_i,
   input  wire [11:0]   s_axi_awaddr_i,
   input  wire          s_axi_awvalid_i,
   output wire          s_axi_awready_o,
   input  wire [31:0]   s_axi_wdata_i,
   input  wire [3:0]    s_axi_wstrb_i,
   input  wire          s_axi_wvalid_i,
   output wire          s_axi_wready_o,
   output reg  [1:0]    s_axi_bresp_o,
   output reg           s_axi_bvalid_o,
   input  wire          s_axi_bready_i,
   input  wire [11:0]   s_axi_araddr_i,
   input  wire          s_axi_arvalid_i,
   output wire          s_axi_arready_o,
   output reg  [31:0]   s_axi_rdata_o,
   output reg  [1:0]    s_axi_rresp_o,
   output reg           s_axi_rvalid_o,
   input  wire          s_axi_rready_i
);

   // ----------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------
   reg rst_meta;
   reg rstn;
   always @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta <= 1'b0;
         rstn     <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rstn     <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [7:0] base_gain;
   reg [7:0] small_edge_gain;
   reg [7:0] medium_edge_gain;
   reg [7:0] large_edge_gain;
   reg [7:0] small_edge_threshold;
   reg [7:0] medium_edge_threshold;
   reg [7:0] large_edge_threshold;
   reg       sharpen_enable;
   reg       adaptive_enable;
   reg       adaptive_variant_select;
   reg [1:0] active_sel;

   // byte address to register index; unaligned or out-of-range gives ff
   function [7:0] addr_index;
      input [11:0] addr;
      begin
         addr_index = (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) ? addr[9:2] : 8'hFF;
      end
   endfunction

   function known_index;
      input [7:0] idx;
      begin
         case (idx)
            `LSAF_IDX_BASE_GAIN, `LSAF_IDX_SMALL_GAIN, `LSAF_IDX_MEDIUM_GAIN,
            `LSAF_IDX_LARGE_GAIN, `LSAF_IDX_SMALL_THR, `LSAF_IDX_MEDIUM_THR,
            `LSAF_IDX_LARGE_THR, `LSAF_IDX_CONTROL, `LSAF_IDX_STATUS:
               known_index = 1'b1;
            default:
               known_index = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   reg         aw_held;
   reg [11:0]  aw_addr;
   reg         w_held;
   reg [31:0]  w_data;
   reg [3:0]   w_strb;
   wire        do_write;
   wire [7:0]  wr_idx;

   // one write outstanding: hold off address and data until the response leaves
   assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o & rstn;
   assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o & rstn;
   assign do_write        = aw_held & w_held;
   assign wr_idx          = addr_index(aw_addr);

   always @(posedge clk_sys_i or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_held                 <= 1'b0;
         aw_addr                 <= 12'h000;
         w_held                  <= 1'b0;
         w_data                  <= 32'h00000000;
         w_strb                  <= 4'h0;
         s_axi_bvalid_o          <= 1'b0;
         s_axi_bresp_o           <= `LSAF_RESP_OKAY;
         base_gain               <= `LSAF_RST_GAIN;
         small_edge_gain         <= `LSAF_RST_GAIN;
         medium_edge_gain        <= `LSAF_RST_GAIN;
         large_edge_gain         <= `LSAF_RST_GAIN;
         small_edge_threshold    <= `LSAF_RST_THR;
         medium_edge_threshold   <= `LSAF_RST_THR;
         large_edge_threshold    <= `LSAF_RST_THR;
         sharpen_enable          <= 1'b0;
         adaptive_enable         <= 1'b0;
         adaptive_variant_select <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (do_write)
         begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= known_index(wr_idx) ? `LSAF_RESP_OKAY : `LSAF_RESP_SLVERR;
            // only byte lane 0 carries register data
            if (w_strb[0])
            begin
               case (wr_idx)
                  `LSAF_IDX_BASE_GAIN:   base_gain        <= w_data[7:0];
                  `LSAF_IDX_SMALL_GAIN:  small_edge_gain  <= w_data[7:0];
                  `LSAF_IDX_MEDIUM_GAIN: medium_edge_gain <= w_data[7:0];
                  `LSAF_IDX_LARGE_GAIN:  large_edge_gain  <= w_data[7:0];
                  `LSAF_IDX_SMALL_THR:   small_edge_threshold  <= w_data[7:0];
                  `LSAF_IDX_MEDIUM_THR:  medium_edge_threshold <= w_data[7:0];
                  `LSAF_IDX_LARGE_THR:   large_edge_threshold  <= w_data[7:0];
                  `LSAF_IDX_CONTROL:
                  begin
                     sharpen_enable          <= w_data[`LSAF_CTRL_SHARPEN];
                     adaptive_enable         <= w_data[`LSAF_CTRL_ADAPTIVE];
                     adaptive_variant_select <= w_data[`LSAF_CTRL_VARIANT];
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         else if (s_axi_bvalid_o && s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   reg [31:0] rd_word;
   wire [7:0] rd_idx;

   assign s_axi_arready_o = ~s_axi_rvalid_o & rstn;
   assign rd_idx          = addr_index(s_axi_araddr_i);

   always @*
   begin
      rd_word = 32'h00000000;
      case (rd_idx)
         `LSAF_IDX_BASE_GAIN:   rd_word[7:0] = base_gain;
         `LSAF_IDX_SMALL_GAIN:  rd_word[7:0] = small_edge_gain;
         `LSAF_IDX_MEDIUM_GAIN: rd_word[7:0] = medium_edge_gain;
         `LSAF_IDX_LARGE_GAIN:  rd_word[7:0] = large_edge_gain;
         `LSAF_IDX_SMALL_THR:   rd_word[7:0] = small_edge_threshold;
         `LSAF_IDX_MEDIUM_THR:  rd_word[7:0] = medium_edge_threshold;
         `LSAF_IDX_LARGE_THR:   rd_word[7:0] = large_edge_threshold;
         `LSAF_IDX_CONTROL:
            rd_word[2:0] = {adaptive_variant_select, adaptive_enable, sharpen_enable};
         `LSAF_IDX_STATUS:      rd_word[1:0] = active_sel;
         default:               rd_word = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys_i or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h00000000;
         s_axi_rresp_o  <= `LSAF_RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= rd_word;
         s_axi_rresp_o  <= known_index(rd_idx) ? `LSAF_RESP_OKAY : `LSAF_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // ----------------------------------------------------------------
   // input fifo
   // ----------------------------------------------------------------
   wire [DW-1:0] fifo_data;
   wire          fifo_valid;
   wire          advance;

   lsaf_fifo
   #(
      .WIDTH (DW),
      .DEPTH (DEPTH),
      .AW    (AW)
   )
   u_fifo
   (
      .clk_i       (clk_sys_i),
      .rstn_i      (rstn),
      .in_data_i   (luma_in_data_i),
      .in_valid_i  (luma_in_valid_i),
      .in_ready_o  (luma_in_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (advance)
   );

   // output stage stalls fifo reads and the history registers when it holds a sample and downstream holds ready low
   assign advance = fifo_valid & (~luma_out_valid_o | luma_out_ready_i);

   // ----------------------------------------------------------------
   // edge classification
   // ----------------------------------------------------------------
   reg  [DW-1:0] prev1;
   reg  [DW-1:0] prev2;
   wire [DW:0]   diff;
   wire [DW-1:0] mag;
   wire [7:0]    mag8;
   reg  [1:0]    next_sel;
   wire          sharp_mode;
   wire          adapt_mode;

   assign sharp_mode = sharpen_enable & ~adaptive_enable;
   assign adapt_mode = sharpen_enable & adaptive_enable;

   assign diff = {1'b0, fifo_data} - {1'b0, prev1};
   assign mag  = diff[DW] ? (prev1 - fifo_data) : diff[DW-1:0];
   // thresholds are 8-bit; compare against the top 8 bits of the magnitude
   assign mag8 = mag[DW-1:DW-8];

   always @*
   begin
      next_sel = `LSAF_SEL_BASE;
      if (mag8 > large_edge_threshold)
         next_sel = `LSAF_SEL_LARGE;
      else if (mag8 > medium_edge_threshold)
         next_sel = `LSAF_SEL_MEDIUM;
      else if (mag8 > small_edge_threshold)
         next_sel = `LSAF_SEL_SMALL;
      else
         next_sel = `LSAF_SEL_BASE;
      if (!adapt_mode)
         next_sel = `LSAF_SEL_BASE;
   end

   // ----------------------------------------------------------------
   // gain selection and filtering
   // ----------------------------------------------------------------
   reg  [7:0]         gain_reg;
   wire signed [4:0]  gain_a;
   wire signed [4:0]  gain_b;
   wire signed [DW+2:0] cur;
   wire signed [DW+2:0] hp_a;
   wire signed [DW+2:0] hp_b;
   wire signed [DW+8:0] sum;
   wire [DW-1:0]      filtered;

   // one gain register drives the filter
   always @*
   begin
      case (next_sel)
         `LSAF_SEL_MEDIUM: gain_reg = medium_edge_gain;
         `LSAF_SEL_LARGE:  gain_reg = large_edge_gain;
         `LSAF_SEL_SMALL:  gain_reg = small_edge_gain;
         default:          gain_reg = base_gain;
      endcase
   end

   // variant A holds gain A at zero; variant B uses both
   assign gain_a = (adapt_mode && !adaptive_variant_select) ? 5'sd0 :
                   $signed({gain_reg[`LSAF_GAIN_A_LSB+3],
                            gain_reg[`LSAF_GAIN_A_LSB+3:`LSAF_GAIN_A_LSB]});
   assign gain_b = $signed({gain_reg[`LSAF_GAIN_B_LSB+3],
                            gain_reg[`LSAF_GAIN_B_LSB+3:`LSAF_GAIN_B_LSB]});

   // filter A: first difference; filter B: second difference around prev1
   assign cur  = $signed({3'b000, fifo_data});
   assign hp_a = cur - $signed({3'b000, prev1});
   assign hp_b = $signed({2'b00, prev1, 1'b0}) - cur - $signed({3'b000, prev2});
   // gains step in eighths of the detail term; all terms kept at the width of sum
   assign sum  = ($signed({6'b000000, fifo_data, 3'b000}) + hp_a * gain_a + hp_b * gain_b) >>> 3;

   function [DW-1:0] clip;
      input signed [DW+8:0] v;
      begin
         if (v < 0)
            clip = {DW{1'b0}};
         else if (v > $signed({9'h000, {DW{1'b1}}}))
            clip = {DW{1'b1}};
         else
            clip = v[DW-1:0];
      end
   endfunction

   assign filtered = clip(sum);

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i or negedge rstn)
   begin
      if (!rstn)
      begin
         prev1            <= {DW{1'b0}};
         prev2            <= {DW{1'b0}};
         active_sel       <= `LSAF_SEL_BASE;
         luma_out_data_o  <= {DW{1'b0}};
         luma_out_valid_o <= 1'b0;
      end
      else
      begin
         if (advance)
         begin
            prev1            <= fifo_data;
            prev2            <= prev1;
            active_sel       <= next_sel;
            luma_out_valid_o <= 1'b1;
            luma_out_data_o  <= (sharp_mode || adapt_mode) ? filtered : fifo_data;
         end
         else if (luma_out_ready_i)
            luma_out_valid_o <= 1'b0;
      end
   end
endmodule // lsaf_filter

// File: design/lsaf_defines.vh
// register offsets, field positions, reset values, gain selector codes and axi responses of the luma sharpness filter
`ifndef LSAF_DEFINES_VH
`define LSAF_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define LSAF_IDX_BASE_GAIN      8'h10
`define LSAF_IDX_SMALL_GAIN     8'h22
`define LSAF_IDX_MEDIUM_GAIN    8'h23
`define LSAF_IDX_LARGE_GAIN     8'h24
`define LSAF_IDX_SMALL_THR      8'h25
`define LSAF_IDX_MEDIUM_THR     8'h26
`define LSAF_IDX_LARGE_THR      8'h27
`define LSAF_IDX_CONTROL        8'h30
`define LSAF_IDX_STATUS         8'h31

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSAF_GAIN_A_LSB         0
`define LSAF_GAIN_B_LSB         4
`define LSAF_CTRL_SHARPEN       0
`define LSAF_CTRL_ADAPTIVE      1
`define LSAF_CTRL_VARIANT       2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSAF_RST_GAIN           8'h00
`define LSAF_RST_THR            8'h00
`define LSAF_RST_CTRL           3'h0

// ----------------------------------------------------------------
// gain selector codes
// ----------------------------------------------------------------
`define LSAF_SEL_BASE           2'h0
`define LSAF_SEL_SMALL          2'h1
`define LSAF_SEL_MEDIUM         2'h2
`define LSAF_SEL_LARGE          2'h3

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define LSAF_RESP_OKAY          2'h0
`define LSAF_RESP_SLVERR        2'h2

`endif

// File: design/lsaf_fifo.v
// synchronous valid/ready fifo used on the luma input path
`timescale 1ns/1ps
module lsaf_fifo
#(
   parameter WIDTH = 10,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire             clk_i,
   input  wire             rstn_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // lsaf_fifo

// File: tb/lsaf_filter_checker.sv
// port assertions for the luma sharpness filter
`timescale 1ns/1ps
module lsaf_filter_checker
#(
   parameter DW = 10
)
(
   input wire          clk_sys_i,
   input wire          rstn_i,
   input wire [DW-1:0] luma_out_data_o,
   input wire          luma_out_valid_o,
   input wire          luma_out_ready_i,
   input wire          s_axi_awvalid_i,
   input wire          s_axi_awready_o,
   input wire          s_axi_wvalid_i,
   input wire          s_axi_wready_o,
   input wire          s_axi_bvalid_o,
   input wire          s_axi_bready_i,
   input wire          s_axi_arvalid_i,
   input wire          s_axi_arready_o,
   input wire [31:0]   s_axi_rdata_o,
   input wire          s_axi_rvalid_o,
   input wire          s_axi_rready_i
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // a stalled sample must not change under the downstream stage
   chk_out_hold: assert property (luma_out_valid_o && !luma_out_ready_i |=>
      luma_out_valid_o && $stable(luma_out_data_o)) else $error("luma output changed");
   // address and data are latched first, the response follows one cycle later
   chk_b_after: assert property (s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_wvalid_i && s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("late bvalid");
   chk_b_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
      $fell(s_axi_bvalid_o)) else $error("bvalid repeated");
   chk_r_after: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
      s_axi_rvalid_o) else $error("late rvalid");
   chk_r_once: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
      !s_axi_rvalid_o) else $error("rvalid repeated");
   // registers are one byte wide, upper read bits stay zero
   chk_r_byte: assert property (s_axi_rvalid_o |->
      s_axi_rdata_o[31:8] == 24'h000000) else $error("read upper bits set");
   chk_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("arready during rvalid");
   chk_aw_block: assert property (s_axi_bvalid_o |->
      !s_axi_awready_o && !s_axi_wready_o) else $error("write ready during bvalid");
endmodule // lsaf_filter_checker

bind lsaf_filter lsaf_filter_checker #(.DW(DW)) i_lsaf_filter_checker (.clk_sys_i,
   .rstn_i, .luma_out_data_o, .luma_out_valid_o, .luma_out_ready_i, .s_axi_awvalid_i,
   .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
   .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i);

// File: tb/lsaf_src.sv
// upstream luma source model with valid/ready handshake
`timescale 1ns/1ps
module lsaf_src
(
   input  wire       clk_i,
   input  wire       ready_i,
   output reg  [9:0] data_o,
   output reg        valid_o,
   output reg        stuck_o
);
   initial
   begin
      data_o = 10'h000;
      valid_o = 1'b0;
      stuck_o = 1'b0;
   end
   // idle data toggles during the gap and is inverted after each sample so nobody can lean on a stale sample
   task send(input [9:0] v, input integer gap);
      integer n;
      begin
         @(posedge clk_i);
         repeat (gap) @(posedge clk_i) data_o <= ~data_o;
         valid_o <= 1'b1;
         data_o <= v;
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (!ready_i && n < 200);
         if (n >= 200) stuck_o = 1'b1;
         valid_o <= 1'b0;
         data_o <= ~v;
      end
   endtask
endmodule // lsaf_src

// File: tb/luma_sharpness_adaptive_filter_tb.sv
// self-checking bench for the luma sharpness filter
`timescale 1ns/1ps
`include "lsaf_defines.vh"
module luma_sharpness_adaptive_filter_tb;
   localparam logic [11:0] RA [0:7] = '{`LSAF_IDX_BASE_GAIN*4, `LSAF_IDX_SMALL_GAIN*4,
      `LSAF_IDX_MEDIUM_GAIN*4, `LSAF_IDX_LARGE_GAIN*4, `LSAF_IDX_SMALL_THR*4,
      `LSAF_IDX_MEDIUM_THR*4, `LSAF_IDX_LARGE_THR*4, `LSAF_IDX_CONTROL*4};
   localparam logic [11:0] A_ST = `LSAF_IDX_STATUS*4;
   reg clk_sys_i = 1'b0, rstn_i = 1'b0, luma_out_ready_i = 1'b0;
   reg [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
   reg [31:0] s_axi_wdata_i = 32'h00000000;
   reg s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   reg s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   wire [9:0] luma_in_data_i, luma_out_data_o;
   wire [31:0] s_axi_rdata_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire luma_in_valid_i, luma_in_ready_o, luma_out_valid_o, src_stuck;
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   integer bad_count = 0, checks_done = 0, h1 = 0, h2 = 0;
   reg [7:0] g [0:3];
   reg [7:0] ta, tm, tl;
   reg [2:0] ctl;

   always #2.5 clk_sys_i = ~clk_sys_i;

   lsaf_filter i_lsaf_filter (.clk_sys_i, .rstn_i, .luma_in_data_i, .luma_in_valid_i,
      .luma_in_ready_o, .luma_out_data_o, .luma_out_valid_o, .luma_out_ready_i,
      .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
      .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
      .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
   lsaf_src i_lsaf_src (.clk_i(clk_sys_i), .ready_i(luma_in_ready_o),
      .data_o(luma_in_data_i), .valid_o(luma_in_valid_i), .stuck_o(src_stuck));

   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         checks_done++;
         if (got !== exp)
         begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
         end
      end
   endtask
   task hang(input string nm);
      begin
         check(nm, 1, 0);
         summarize;
      end
   endtask
   task axi_wr(input [11:0] a, input [31:0] d, input [1:0] er);
      integer n;
      begin
         @(posedge clk_sys_i);
         s_axi_awaddr_i <= a;
         s_axi_wdata_i <= d;
         s_axi_awvalid_i <= 1'b1;
         s_axi_wvalid_i <= 1'b1;
         s_axi_bready_i <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         end
         while (!s_axi_bvalid_o && n < 200);
         if (n >= 200) hang("bvalid wait");
         s_axi_bready_i <= 1'b0;
         check("bresp", er, s_axi_bresp_o);
      end
   endtask
   task axi_rd(input [11:0] a, input [31:0] ed, input [1:0] er);
      integer n;
      begin
         @(posedge clk_sys_i);
         s_axi_araddr_i <= a;
         s_axi_arvalid_i <= 1'b1;
         s_axi_rready_i <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         end
         while (!s_axi_rvalid_o && n < 200);
         if (n >= 200) hang("rvalid wait");
         s_axi_rready_i <= 1'b0;
         check("rresp", er, s_axi_rresp_o);
         check("rdata", ed, s_axi_rdata_o);
      end
   endtask
   task get_out(output logic [9:0] y);
      integer n;
      begin
         luma_out_ready_i <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys_i);
            n++;
         end
         while (!luma_out_valid_o && n < 200);
         if (n >= 200 || src_stuck) hang("luma wait");
         y = luma_out_data_o;
      end
   endtask
   task set_all(input [2:0] c, input [7:0] b, s, m, l, t0, t1, t2);
      integer k;
      begin
         g[0] = b;
         g[1] = s;
         g[2] = m;
         g[3] = l;
         ta = t0;
         tm = t1;
         tl = t2;
         ctl = c;
         for (k = 0; k < 4; k++) axi_wr(RA[k], g[k], `LSAF_RESP_OKAY);
         axi_wr(RA[4], ta, `LSAF_RESP_OKAY);
         axi_wr(RA[5], tm, `LSAF_RESP_OKAY);
         axi_wr(RA[6], tl, `LSAF_RESP_OKAY);
         axi_wr(RA[7], ctl, `LSAF_RESP_OKAY);
      end
   endtask
   // one sample through the filter, output and chosen gain both judged
   task step(input integer x);
      integer d, sel, ga, gb, v;
      logic [9:0] y;
      begin
         d = (x > h1 ? x - h1 : h1 - x) >> 2;
         sel = 0;
         if (ctl[0] && ctl[1]) sel = d > tl ? 3 : d > tm ? 2 : d > ta ? 1 : 0;
         ga = $signed(g[sel][3:0]);
         gb = $signed(g[sel][7:4]);
         if (ctl == 3'h3) ga = 0;
         v = (8 * x + ga * (x - h1) + gb * (2 * h1 - x - h2)) >>> 3;
         v = v < 0 ? 0 : v > 1023 ? 1023 : v;
         if (!ctl[0]) v = x;
         i_lsaf_src.send(x[9:0], 1);
         get_out(y);
         check("luma_out", v, y);
         axi_rd(A_ST, sel, `LSAF_RESP_OKAY);
         h2 = h1;
         h1 = x;
      end
   endtask

   task sc_regs;
      integer k;
      reg [7:0] v;
      begin
         for (k = 0; k < 8; k++)
         begin
            v = 8'hFF - 8'h11 * k;
            axi_rd(RA[k], 0, `LSAF_RESP_OKAY);
            axi_wr(RA[k], {24'hFFFFFF, v}, `LSAF_RESP_OKAY);
            axi_rd(RA[k], k == 7 ? v & 8'h07 : v, `LSAF_RESP_OKAY);
         end
         axi_wr(12'h3F0, 32'h00000001, `LSAF_RESP_SLVERR);
         axi_rd(12'h3F0, 0, `LSAF_RESP_SLVERR);
      end
   endtask
   // stall the output until the buffer refuses, then drain in order
   task sc_fill;
      integer n, k;
      logic [9:0] y;
      begin
         set_all(3'h2, 8'h77, 8'h77, 8'h77, 8'h77, 8'h00, 8'h00, 8'h00);
         @(posedge clk_sys_i);
         luma_out_ready_i <= 1'b0;
         n = 0;
         repeat (3) @(posedge clk_sys_i);
         while (luma_in_ready_o && n < 24)
         begin
            i_lsaf_src.send(10'h025 * n, 0);
            n++;
            repeat (2) @(posedge clk_sys_i);
         end
         // sixteen in the buffer plus one held in the stalled output register
         check("fill_count", 17, n);
         for (k = 0; k < n; k++)
         begin
            get_out(y);
            check("drain", 10'h025 * k, y);
         end
         h2 = 37 * (n - 2);
         h1 = 37 * (n - 1);
      end
   endtask
   task sc_sharp;
      integer k;
      begin
         set_all(3'h1, 8'h87, 8'h11, 8'h22, 8'h33, 8'h00, 8'h01, 8'h02);
         for (k = 0; k < 7; k++) step(k[0] ? 900 - 60 * k : 100 + 150 * k);
         g[0] = 8'h78;
         axi_wr(RA[0], g[0], `LSAF_RESP_OKAY);
         for (k = 0; k < 7; k++) step(k[0] ? 1023 : 20 * k);
      end
   endtask
   task sc_adapt;
      integer seq [0:8];
      integer k, m;
      begin
         seq = '{500, 500, 560, 628, 500, 632, 890, 630, 890};
         for (m = 0; m < 2; m++)
         begin
            set_all(m ? 3'h7 : 3'h3, 8'h11, 8'hAC, 8'h9A, 8'h88, 8'h10, 8'h20, 8'h40);
            for (k = 0; k < 9; k++) step(seq[k]);
         end
      end
   endtask

   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      sc_regs;
      sc_fill;
      sc_sharp;
      sc_adapt;
      summarize;
   end
endmodule // luma_sharpness_adaptive_filter_tb
